// ===== core/bsc_pkg.sv
package bsc_pkg;

	// pin count and per-pin cell layout: pull-up, control, data
	localparam int BSC_NPINS = 8;
	localparam int PIN_PU = 0;
	localparam int PIN_OC = 1;
	localparam int PIN_ID = 2;
	localparam int PIN_CELLS = 3;

	// cells after the pin cells, offset from the first cell past the pin cells
	localparam int TAIL_RST_LOW = 0;
	localparam int TAIL_RST_HV = 1;
	localparam int TAIL_EXT_EN = 2;
	localparam int TAIL_EXT_CK = 3;
	localparam int TAIL_OSC_EN = 4;
	localparam int TAIL_OSC_CK = 5;
	localparam int TAIL_LF_EN = 6;
	localparam int TAIL_LF_CK = 7;
	localparam int TAIL_AC_OFF = 8;
	localparam int TAIL_AC_OUT = 9;
	localparam int TAIL_AC_MUX = 10;
	localparam int TAIL_AC_BG = 11;
	localparam int TAIL_LEN = 12;

	// scanned clock line level when the option is not used
	localparam logic EXT_CK_IDLE = 1'h0;
	localparam logic OSC_CK_IDLE = 1'h1;
	localparam logic LF_CK_IDLE = 1'h1;

	// reset value of every chain, update and output flop except padOe_n, which resets to its inverse
	localparam logic RST_BIT = 1'h0;

	// test access port state seen by the chain
	typedef struct packed {
		logic capture;
		logic shift;
		logic update;
		logic extest;
		logic sample;
	} bsc_tap_t;

	// oscillator and clock lines coming in from the pins
	typedef struct packed {
		logic extLine;
		logic crystal;
		logic lowFreq;
	} bsc_clk_t;

	function automatic int pinIdx(input int pin, input int field);
		return pin * PIN_CELLS + field;
	endfunction

endpackage

// ===== core/bsc_sync.sv
`timescale 1ns/1ns
module bsc_sync
	import bsc_pkg::*;
#(
	parameter int W = 1
) (
	input wire logic clock, // system clock
	input wire logic rstn, // async reset, active low
	input wire logic [W-1:0] asyncIn, // signals from outside the domain
	output logic [W-1:0] syncOut // second stage, safe to read
);

	logic [W-1:0] stage1;
	logic [W-1:0] next_stage1;
	logic [W-1:0] next_syncOut;

	// first stage feeds only the second
	always_comb begin
		next_stage1 = asyncIn;
		next_syncOut = stage1;
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			stage1 <= {W{RST_BIT}};
			syncOut <= {W{RST_BIT}};
		end else begin
			stage1 <= next_stage1;
			syncOut <= next_syncOut;
		end
	end
endmodule

// ===== core/bsc_boundary_scan.sv
`timescale 1ns/1ns
// Notes on behaviour
// - input data cell samples raw pin level
// - output data latch bit, control direction bit
// - pull-up is not-disable, not-direction, latch
// - alternate functions sit outside scanned pins
// - analog paths direct; cells on digital-analog signals
// - reset pin has two observe-only cells
// - oscillator enable general cell, clock observe-only
// - timer oscillator scanned like main oscillator
// - internal RC oscillator has no cell
// - unused clock lines read 0, 1, 1
// - oscillator enables are reachable in chain
// - four comparator signals have general cells
// - least significant bit shifted first
// - capture samples external pins on extest, sample
module bsc_boundary_scan
	import bsc_pkg::*;
#(
	parameter int NPINS = BSC_NPINS
) (
	input wire logic clock, // system clock
	input wire logic rstn, // async reset, active low
	input wire logic tck, // test clock, sampled
	input wire logic tdi, // test data in
	input wire bsc_tap_t tap, // tap state and instruction
	output logic tdo, // test data out
	input wire logic [NPINS-1:0] padIn, // pin levels
	output logic [NPINS-1:0] padOut, // pin drive value
	output logic [NPINS-1:0] padOe_n, // pin drive enable, low drives
	output logic [NPINS-1:0] padPullup, // pin pull-up on
	input wire logic [NPINS-1:0] outputLatchBit, // port latch
	input wire logic [NPINS-1:0] directionBit, // data direction
	input wire logic pullupGlobalDisable, // global pull-up off
	output logic [NPINS-1:0] pinInputRegister, // port input value
	input wire logic resetLowObserve, // reset pin, normal path
	input wire logic resetHighVoltObserve, // reset pin, 12V detect
	input wire bsc_clk_t clkIn, // clock lines from pins
	input wire logic extClockUsed, // fuse: external clock
	input wire logic crystalOscUsed, // fuse: crystal/resonator
	input wire logic lowFreqOscUsed, // fuse: timer crystal
	input wire logic extClockEnableSys, // enable from sleep logic
	input wire logic crystalOscEnableSys, // enable from sleep logic
	input wire logic lowFreqOscEnableSys, // enable from sleep logic
	output logic extClockEnable, // enable to clock input
	output logic crystalOscEnable, // enable to oscillator
	output logic lowFreqOscEnable, // enable to timer oscillator
	input wire logic comparatorOffSys, // from cpu
	input wire logic comparatorMuxSelectSys, // from cpu
	input wire logic comparatorBandgapSelectSys, // from cpu
	output logic comparatorOff, // to analog comparator
	output logic comparatorMuxSelect, // to analog comparator
	output logic comparatorBandgapSelect, // to analog comparator
	input wire logic comparatorOutputRaw, // from analog comparator
	output logic comparatorOutput // to cpu
);
	localparam int TB = NPINS * PIN_CELLS;
	localparam int CHAIN_LEN = TB + TAIL_LEN;
	localparam int SYNC_W = NPINS + 13;

	logic [SYNC_W-1:0] syncIn;
	logic [SYNC_W-1:0] syncOut;
	logic tckS;
	logic tdiS;
	bsc_tap_t tapS;
	logic [NPINS-1:0] padS;
	logic rstLowS;
	logic rstHvS;
	bsc_clk_t clkS;
	logic acOutS;

	logic tckD;
	logic [CHAIN_LEN-1:0] chain;
	logic [CHAIN_LEN-1:0] upd;
	logic next_tckD;
	logic [CHAIN_LEN-1:0] next_chain;
	logic [CHAIN_LEN-1:0] next_upd;
	logic next_tdo;

	logic tckRise;
	logic tckFall;
	logic chainSel;
	logic [CHAIN_LEN-1:0] capVec;
	logic [NPINS-1:0] pullNorm;
	logic [NPINS-1:0] updOd;
	logic [NPINS-1:0] updOc;
	logic [NPINS-1:0] updPu;

	logic [NPINS-1:0] next_padOut;
	logic [NPINS-1:0] next_padOe_n;
	logic [NPINS-1:0] next_padPullup;
	logic [NPINS-1:0] next_pinInputRegister;
	logic next_extClockEnable;
	logic next_crystalOscEnable;
	logic next_lowFreqOscEnable;
	logic next_comparatorOff;
	logic next_comparatorMuxSelect;
	logic next_comparatorBandgapSelect;
	logic next_comparatorOutput;

	// everything arriving from pins, the analog comparator or the test clock domain
	assign syncIn = {tck, tdi, tap, padIn, resetLowObserve,
		resetHighVoltObserve, clkIn, comparatorOutputRaw};

	bsc_sync #(
		.W(SYNC_W)
	) u_sync (
		.clock(clock),
		.rstn(rstn),
		.asyncIn(syncIn),
		.syncOut(syncOut)
	);

	assign {tckS, tdiS, tapS, padS, rstLowS, rstHvS, clkS, acOutS} = syncOut;

	assign tckRise = tckS & ~tckD;
	assign tckFall = ~tckS & tckD;
	assign chainSel = tapS.extest | tapS.sample;
	assign pullNorm = ~{NPINS{pullupGlobalDisable}} & ~directionBit
		& outputLatchBit;

	// capture vector and update fields per pin
	always_comb begin
		capVec = {CHAIN_LEN{RST_BIT}};
		updOd = {NPINS{RST_BIT}};
		updOc = {NPINS{RST_BIT}};
		updPu = {NPINS{RST_BIT}};
		for (int i = 0; i < NPINS; i++) begin
			capVec[pinIdx(i, PIN_PU)] = padPullup[i];
			capVec[pinIdx(i, PIN_OC)] = ~padOe_n[i];
			// raw pin, not the port input register
			capVec[pinIdx(i, PIN_ID)] = padS[i];
			updPu[i] = upd[pinIdx(i, PIN_PU)];
			updOc[i] = upd[pinIdx(i, PIN_OC)];
			updOd[i] = upd[pinIdx(i, PIN_ID)];
		end
		capVec[TB + TAIL_RST_LOW] = rstLowS;
		capVec[TB + TAIL_RST_HV] = rstHvS;
		// internal RC oscillator has no cell here
		capVec[TB + TAIL_EXT_EN] = extClockEnable;
		capVec[TB + TAIL_EXT_CK] = extClockUsed ? clkS.extLine
			: EXT_CK_IDLE;
		capVec[TB + TAIL_OSC_EN] = crystalOscEnable;
		capVec[TB + TAIL_OSC_CK] = crystalOscUsed ? clkS.crystal
			: OSC_CK_IDLE;
		capVec[TB + TAIL_LF_EN] = lowFreqOscEnable;
		capVec[TB + TAIL_LF_CK] = lowFreqOscUsed ? clkS.lowFreq
			: LF_CK_IDLE;
		capVec[TB + TAIL_AC_OFF] = comparatorOff;
		capVec[TB + TAIL_AC_OUT] = acOutS;
		capVec[TB + TAIL_AC_MUX] = comparatorMuxSelect;
		capVec[TB + TAIL_AC_BG] = comparatorBandgapSelect;
	end

	// chain: capture and shift on tck rise, update and tdo on tck fall
	always_comb begin
		next_tckD = tckS;
		next_chain = chain;
		next_upd = upd;
		next_tdo = tdo;
		if (tckRise && chainSel) begin
			if (tapS.capture) begin
				next_chain = capVec;
			end else if (tapS.shift) begin
				next_chain = {tdiS, chain[CHAIN_LEN-1:1]};
			end
		end
		if (tckFall && chainSel) begin
			if (tapS.update) begin
				next_upd = chain;
			end
			if (tapS.shift) begin
				next_tdo = chain[0];
			end
		end
	end

	// outputs except pinInputRegister: update cells drive under extest, system logic (comparatorOutput: the analog comparator) otherwise
	always_comb begin
		next_pinInputRegister = padS;
		if (tapS.extest) begin
			next_padOut = updOd;
			next_padOe_n = ~updOc;
			next_padPullup = updPu & ~updOc;
			next_extClockEnable = upd[TB + TAIL_EXT_EN];
			next_crystalOscEnable = upd[TB + TAIL_OSC_EN];
			next_lowFreqOscEnable = upd[TB + TAIL_LF_EN];
			next_comparatorOff = upd[TB + TAIL_AC_OFF];
			next_comparatorMuxSelect = upd[TB + TAIL_AC_MUX];
			next_comparatorBandgapSelect = upd[TB + TAIL_AC_BG];
			next_comparatorOutput = upd[TB + TAIL_AC_OUT];
		end else begin
			next_padOut = outputLatchBit;
			next_padOe_n = ~directionBit;
			next_padPullup = pullNorm;
			next_extClockEnable = extClockEnableSys;
			next_crystalOscEnable = crystalOscEnableSys;
			next_lowFreqOscEnable = lowFreqOscEnableSys;
			next_comparatorOff = comparatorOffSys;
			next_comparatorMuxSelect = comparatorMuxSelectSys;
			next_comparatorBandgapSelect = comparatorBandgapSelectSys;
			next_comparatorOutput = acOutS;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			tckD <= RST_BIT;
			chain <= {CHAIN_LEN{RST_BIT}};
			upd <= {CHAIN_LEN{RST_BIT}};
			tdo <= RST_BIT;
			padOut <= {NPINS{RST_BIT}};
			padOe_n <= {NPINS{~RST_BIT}};
			padPullup <= {NPINS{RST_BIT}};
			pinInputRegister <= {NPINS{RST_BIT}};
			extClockEnable <= RST_BIT;
			crystalOscEnable <= RST_BIT;
			lowFreqOscEnable <= RST_BIT;
			comparatorOff <= RST_BIT;
			comparatorMuxSelect <= RST_BIT;
			comparatorBandgapSelect <= RST_BIT;
			comparatorOutput <= RST_BIT;
		end else begin
			tckD <= next_tckD;
			chain <= next_chain;
			upd <= next_upd;
			tdo <= next_tdo;
			padOut <= next_padOut;
			padOe_n <= next_padOe_n;
			padPullup <= next_padPullup;
			pinInputRegister <= next_pinInputRegister;
			extClockEnable <= next_extClockEnable;
			crystalOscEnable <= next_crystalOscEnable;
			lowFreqOscEnable <= next_lowFreqOscEnable;
			comparatorOff <= next_comparatorOff;
			comparatorMuxSelect <= next_comparatorMuxSelect;
			comparatorBandgapSelect <= next_comparatorBandgapSelect;
			comparatorOutput <= next_comparatorOutput;
		end
	end

	property p_pin_capture;
		@(posedge clock) disable iff (!rstn)
		(tckRise && chainSel && tapS.capture)
			|=> chain[pinIdx(0, PIN_ID)] == $past(padS[0]);
	endproperty
	a_pin_capture: assert property (p_pin_capture)
		else $error("pin data cell did not capture pin level");

	property p_normal_drive;
		@(posedge clock) disable iff (!rstn)
		!tapS.extest |=> (padOut == $past(outputLatchBit))
			&& (padOe_n == ~$past(directionBit));
	endproperty
	a_normal_drive: assert property (p_normal_drive)
		else $error("pin drive does not follow latch and direction");

	property p_extest_drive;
		@(posedge clock) disable iff (!rstn)
		tapS.extest |=> (padOe_n == ~$past(updOc))
			&& (padOut == $past(updOd));
	endproperty
	a_extest_drive: assert property (p_extest_drive)
		else $error("pin drive does not follow update cells");

	property p_pullup;
		@(posedge clock) disable iff (!rstn)
		!tapS.extest |=> padPullup == (~$past(directionBit)
			& ~{NPINS{$past(pullupGlobalDisable)}} & $past(outputLatchBit));
	endproperty
	a_pullup: assert property (p_pullup)
		else $error("pull-up enable expression wrong");

	property p_shift_lsb;
		@(posedge clock) disable iff (!rstn)
		(tckRise && chainSel && !tapS.capture && tapS.shift)
			|=> chain[0] == $past(chain[1])
			&& chain[CHAIN_LEN-1] == $past(tdiS);
	endproperty
	a_shift_lsb: assert property (p_shift_lsb)
		else $error("chain did not shift toward bit zero");

	property p_tdo_lsb;
		@(posedge clock) disable iff (!rstn)
		(tckFall && chainSel && tapS.shift) |=> tdo == $past(chain[0]);
	endproperty
	a_tdo_lsb: assert property (p_tdo_lsb)
		else $error("tdo is not chain bit zero");

	property p_ext_idle;
		@(posedge clock) disable iff (!rstn)
		(tckRise && chainSel && tapS.capture && !extClockUsed)
			|=> chain[TB + TAIL_EXT_CK] == 1'h0;
	endproperty
	a_ext_idle: assert property (p_ext_idle)
		else $error("unused external clock line not read as 0");

	property p_osc_idle;
		@(posedge clock) disable iff (!rstn)
		(tckRise && chainSel && tapS.capture && !crystalOscUsed
			&& !lowFreqOscUsed)
			|=> chain[TB + TAIL_OSC_CK] && chain[TB + TAIL_LF_CK];
	endproperty
	a_osc_idle: assert property (p_osc_idle)
		else $error("unused oscillator clock lines not read as 1");

	property p_reset_observe;
		@(posedge clock) disable iff (!rstn)
		(tckRise && chainSel && tapS.capture)
			|=> chain[TB + TAIL_RST_LOW] == $past(rstLowS)
			&& chain[TB + TAIL_RST_HV] == $past(rstHvS);
	endproperty
	a_reset_observe: assert property (p_reset_observe)
		else $error("reset observe cells did not capture");

	property p_osc_enable;
		@(posedge clock) disable iff (!rstn)
		tapS.extest |=> crystalOscEnable == $past(upd[TB + TAIL_OSC_EN])
			&& lowFreqOscEnable == $past(upd[TB + TAIL_LF_EN]);
	endproperty
	a_osc_enable: assert property (p_osc_enable)
		else $error("oscillator enable not driven from update cell");

	property p_comparator;
		@(posedge clock) disable iff (!rstn)
		tapS.extest |=> comparatorOff == $past(upd[TB + TAIL_AC_OFF])
			&& comparatorOutput == $past(upd[TB + TAIL_AC_OUT]);
	endproperty
	a_comparator: assert property (p_comparator)
		else $error("comparator cells not driving under extest");
endmodule

// ===== test/bsc_jtag_ctrl.sv
`timescale 1ns/1ns
module bsc_jtag_ctrl
	import bsc_pkg::*;
#(
	parameter int LEN = 36
) (
	input wire logic clock, // system clock
	input wire logic tdo, // test data out
	output logic tck, // test clock
	output logic tdi, // test data in
	output bsc_tap_t tap // tap state and instruction
);
	initial begin
		tck = 1'h0;
		tdi = 1'h1;
		tap = '0;
	end

	// half a tck period, 400 ns
	task automatic half();
		repeat (4) @(posedge clock);
	endtask

	// capture, shift LEN bits, update; tck stands low outside the frame
	task automatic scan(input logic ex, input logic [LEN-1:0] din,
		output logic [LEN-1:0] dout);
		bsc_tap_t t;
		int i;
		t = '0;
		t.extest = ex;
		t.sample = ~ex;
		t.capture = 1'h1;
		tap <= t;
		half();
		tck <= 1'h1;
		half();
		t.capture = 1'h0;
		t.shift = 1'h1;
		tap <= t;
		half();
		for (i = 0; i < LEN; i++) begin
			tck <= 1'h0;
			tdi <= din[i];
			half();
			dout[i] = tdo;
			tck <= 1'h1;
			half();
		end
		t.shift = 1'h0;
		t.update = 1'h1;
		tap <= t;
		half();
		tck <= 1'h0;
		tdi <= ~din[LEN-1];
		half();
		t.update = 1'h0;
		tap <= t;
		half();
	endtask
endmodule

// ===== test/test_bsc_boundary_scan.sv
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin \
	check_count++; \
	if ((got) !== (exp)) begin \
		err_count++; \
		$display("CHECK FAILED %s exp %h got %h", nm, exp, got); \
	end \
end
module test_bsc_boundary_scan
	import bsc_pkg::*;
;
	localparam int N = BSC_NPINS;
	localparam int TB = PIN_CELLS * N;
	localparam int L = TB + TAIL_LEN;
	logic clock, rstn, tck, tdi, tdo;
	bsc_tap_t tap;
	logic [N-1:0] padIn, padOut, padOe_n, padPullup, extDrive;
	logic [N-1:0] outputLatchBit, directionBit, pinInputRegister;
	logic pullupGlobalDisable, resetLowObserve, resetHighVoltObserve;
	bsc_clk_t clkIn;
	logic extClockUsed, crystalOscUsed, lowFreqOscUsed;
	logic extClockEnableSys, crystalOscEnableSys, lowFreqOscEnableSys;
	logic extClockEnable, crystalOscEnable, lowFreqOscEnable;
	logic comparatorOffSys, comparatorMuxSelectSys;
	logic comparatorBandgapSelectSys, comparatorOutputRaw;
	logic comparatorOff, comparatorMuxSelect, comparatorBandgapSelect;
	logic comparatorOutput;
	int err_count, check_count, cycles;

	// pin wire: the cell when it drives, the board otherwise
	assign padIn = (~padOe_n & padOut) | (padOe_n & extDrive);

	bsc_boundary_scan #(.NPINS(N)) u_bsc_boundary_scan (.clock(clock),
		.rstn(rstn), .tck(tck), .tdi(tdi), .tap(tap), .tdo(tdo),
		.padIn(padIn), .padOut(padOut), .padOe_n(padOe_n),
		.padPullup(padPullup), .outputLatchBit(outputLatchBit),
		.directionBit(directionBit),
		.pullupGlobalDisable(pullupGlobalDisable),
		.pinInputRegister(pinInputRegister),
		.resetLowObserve(resetLowObserve),
		.resetHighVoltObserve(resetHighVoltObserve), .clkIn(clkIn),
		.extClockUsed(extClockUsed), .crystalOscUsed(crystalOscUsed),
		.lowFreqOscUsed(lowFreqOscUsed),
		.extClockEnableSys(extClockEnableSys),
		.crystalOscEnableSys(crystalOscEnableSys),
		.lowFreqOscEnableSys(lowFreqOscEnableSys),
		.extClockEnable(extClockEnable),
		.crystalOscEnable(crystalOscEnable),
		.lowFreqOscEnable(lowFreqOscEnable),
		.comparatorOffSys(comparatorOffSys),
		.comparatorMuxSelectSys(comparatorMuxSelectSys),
		.comparatorBandgapSelectSys(comparatorBandgapSelectSys),
		.comparatorOff(comparatorOff),
		.comparatorMuxSelect(comparatorMuxSelect),
		.comparatorBandgapSelect(comparatorBandgapSelect),
		.comparatorOutputRaw(comparatorOutputRaw),
		.comparatorOutput(comparatorOutput));

	bsc_jtag_ctrl #(.LEN(L)) u_bsc_jtag_ctrl (.clock(clock), .tdo(tdo),
		.tck(tck), .tdi(tdi), .tap(tap));

	// expected capture vector from the bench's own inputs
	function automatic logic [L-1:0] capExp(input logic ex,
		input logic [L-1:0] u);
		logic [L-1:0] v;
		logic oc, od;
		int i;
		v = '0;
		for (i = 0; i < N; i++) begin
			oc = ex ? u[PIN_CELLS*i+PIN_OC] : directionBit[i];
			od = ex ? u[PIN_CELLS*i+PIN_ID] : outputLatchBit[i];
			v[PIN_CELLS*i+PIN_PU] = ex ? u[PIN_CELLS*i+PIN_PU] & ~oc
				: ~pullupGlobalDisable & ~oc & od;
			v[PIN_CELLS*i+PIN_OC] = oc;
			v[PIN_CELLS*i+PIN_ID] = oc ? od : extDrive[i];
		end
		v[TB+TAIL_RST_LOW] = resetLowObserve;
		v[TB+TAIL_RST_HV] = resetHighVoltObserve;
		v[TB+TAIL_EXT_EN] = ex ? u[TB+TAIL_EXT_EN] : extClockEnableSys;
		v[TB+TAIL_EXT_CK] = extClockUsed ? clkIn.extLine : 1'h0;
		v[TB+TAIL_OSC_EN] = ex ? u[TB+TAIL_OSC_EN] : crystalOscEnableSys;
		v[TB+TAIL_OSC_CK] = crystalOscUsed ? clkIn.crystal : 1'h1;
		v[TB+TAIL_LF_EN] = ex ? u[TB+TAIL_LF_EN] : lowFreqOscEnableSys;
		v[TB+TAIL_LF_CK] = lowFreqOscUsed ? clkIn.lowFreq : 1'h1;
		v[TB+TAIL_AC_OFF] = ex ? u[TB+TAIL_AC_OFF] : comparatorOffSys;
		v[TB+TAIL_AC_OUT] = comparatorOutputRaw;
		v[TB+TAIL_AC_MUX] = ex ? u[TB+TAIL_AC_MUX] : comparatorMuxSelectSys;
		v[TB+TAIL_AC_BG] = ex ? u[TB+TAIL_AC_BG]
			: comparatorBandgapSelectSys;
		return v;
	endfunction

	task automatic t_normal();
		logic [7:0] lat, dr, pin;
		int k;
		for (k = 0; k < 4; k++) begin
			lat = 8'h0f << k;
			dr = 8'h55 ^ (8'h33 << k);
			pin = (dr & lat) | (~dr & (8'ha5 ^ lat));
			@(posedge clock);
			outputLatchBit <= lat;
			directionBit <= dr;
			pullupGlobalDisable <= k[0];
			extDrive <= 8'ha5 ^ lat;
			{extClockEnableSys, crystalOscEnableSys,
				lowFreqOscEnableSys} <= k[2:0] ^ 3'h5;
			{comparatorOffSys, comparatorMuxSelectSys,
				comparatorBandgapSelectSys,
				comparatorOutputRaw} <= k[3:0] ^ 4'h9;
			repeat (4) @(posedge clock);
			#1;
			`CHK("padOut", lat, padOut)
			`CHK("padOe_n", ~dr, padOe_n)
			`CHK("padPullup", ~{8{k[0]}} & ~dr & lat, padPullup)
			`CHK("pinInputRegister", pin, pinInputRegister)
			`CHK("enables", k[2:0] ^ 3'h5, {extClockEnable,
				crystalOscEnable, lowFreqOscEnable})
			`CHK("comparator", k[3:0] ^ 4'h9, {comparatorOff,
				comparatorMuxSelect, comparatorBandgapSelect,
				comparatorOutput})
		end
	endtask

	// no fuse option, then one fuse option at a time, all lines opposite to their idle level
	task automatic t_sample();
		logic [L-1:0] din, dout, ex;
		logic [2:0] fz;
		int k;
		for (k = 0; k < 4; k++) begin
			fz = (k == 0) ? 3'h0 : 3'h4 >> (k - 1);
			@(posedge clock);
			{extClockUsed, crystalOscUsed, lowFreqOscUsed} <= fz;
			resetLowObserve <= k[0];
			resetHighVoltObserve <= ~k[1];
			comparatorOutputRaw <= k[1];
			repeat (4) @(posedge clock);
			ex = capExp(1'h0, '0);
			din = ex ^ L'(k);
			u_bsc_jtag_ctrl.scan(1'h0, din, dout);
			`CHK("capture", ex, dout)
			`CHK("reset cells", ex[TB+:2], dout[TB+:2])
			`CHK("clock cells", ex[TB+2+:6], dout[TB+2+:6])
			`CHK("ac cells", ex[TB+8+:4], dout[TB+8+:4])
			`CHK("sample pins", outputLatchBit, padOut)
		end
	endtask

	task automatic t_extest();
		logic [L-1:0] din, dout;
		logic [7:0] pu, oc, od;
		int i;
		din = '0;
		for (i = 0; i < N; i++) begin
			pu[i] = i[0];
			oc[i] = i[1];
			od[i] = i[2];
			din[PIN_CELLS*i+PIN_PU] = i[0];
			din[PIN_CELLS*i+PIN_OC] = i[1];
			din[PIN_CELLS*i+PIN_ID] = i[2];
		end
		din[TB+TAIL_OSC_EN] = 1'h1;
		din[TB+TAIL_AC_OFF] = 1'h1;
		din[TB+TAIL_AC_OUT] = 1'h1;
		@(posedge clock);
		crystalOscEnableSys <= 1'h0;
		extDrive <= 8'h3c;
		u_bsc_jtag_ctrl.scan(1'h1, din, dout);
		repeat (2) @(posedge clock);
		#1;
		`CHK("padOut", od, padOut)
		`CHK("padOe_n", ~oc, padOe_n)
		`CHK("padPullup", pu & ~oc, padPullup)
		`CHK("enables", 3'h2, {extClockEnable, crystalOscEnable,
			lowFreqOscEnable})
		`CHK("comparator", 4'h9, {comparatorOff, comparatorMuxSelect,
			comparatorBandgapSelect, comparatorOutput})
		@(posedge clock);
		u_bsc_jtag_ctrl.scan(1'h1, din, dout);
		`CHK("extest capture", capExp(1'h1, din), dout)
	endtask

	task automatic test_done();
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	initial begin
		clock = 1'h0;
		forever #50 clock = ~clock;
	end

	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			err_count++;
			test_done();
		end
	end

	initial begin
		{err_count, check_count, cycles} = '0;
		rstn = 1'h0;
		outputLatchBit = '0;
		directionBit = '0;
		pullupGlobalDisable = 1'h0;
		extDrive = '0;
		resetLowObserve = 1'h1;
		resetHighVoltObserve = 1'h0;
		// steady lines opposite to idle: ext 1, crystal 0, lowfreq 0
		clkIn = 3'h4;
		{extClockUsed, crystalOscUsed, lowFreqOscUsed} = 3'h0;
		extClockEnableSys = 1'h0;
		crystalOscEnableSys = 1'h0;
		lowFreqOscEnableSys = 1'h0;
		comparatorOffSys = 1'h1;
		comparatorMuxSelectSys = 1'h0;
		comparatorBandgapSelectSys = 1'h0;
		comparatorOutputRaw = 1'h0;
		repeat (8) @(posedge clock);
		rstn <= 1'h1;
		repeat (3) @(posedge clock);
		t_normal();
		t_sample();
		t_extest();
		test_done();
	end
endmodule
